//--- hdl/xst_pkg.sv
// Constants for the execution state timing and bit-operation decode block.
// Assumes a single 250 MHz clock and a fetch unit that presents opcode bytes.
// Function
// - Instruction states equal sum of six cycle counts times their per-cycle costs.
// - Fetch, branch address read and stack cycles on on-chip memory cost two.
// - On-chip RAM byte access costs two; two fetches plus two accesses give eight.
// - Fourth byte high nibble top bit selects plain or inverted bit operation.
// - Register-indirect forms take the nibble after the opcode nibble as register.
// - Absolute forms take the byte after the opcode nibble as 8-bit address.
package xst_pkg;
  localparam logic [3:0] XST_S_MEM       = 4'h2;
  localparam logic [3:0] XST_S_INTERNAL  = 4'h1;
  localparam logic [3:0] XST_S_PERIPH_2  = 4'h2;
  localparam logic [3:0] XST_S_PERIPH_3  = 4'h3;
  localparam logic [3:0] XST_OP_REG_IND0 = 4'h7;
  localparam logic [3:0] XST_OP_IND_LO   = 4'hc;
  localparam logic [3:0] XST_OP_IND_HI   = 4'hd;
  localparam logic [3:0] XST_OP_ABS_LO   = 4'he;
  localparam logic [3:0] XST_OP_ABS_HI   = 4'hf;
  localparam int         XST_INV_BIT     = 7;
  localparam int         XST_CNT_W       = 4;
  localparam int         XST_SUM_W       = 12;
endpackage

//--- hdl/xst_exec_timing.sv
// Bit-operation field decoder and execution state calculator.
// Assumes cycle counts and access-location flags arrive with a start strobe.
`timescale 1ns/1ps
`default_nettype none
module xst_exec_timing
  import xst_pkg::*;
(
  input  wire logic                 mclk_in,          // System clock
  input  wire logic                 reset_in,         // Synchronous reset, high
  input  wire logic [31:0]          opcode_in,        // Bytes 1..4, byte 1 in [31:24]
  input  wire logic                 calc_start_in,    // Start a calculation
  input  wire logic [XST_CNT_W-1:0] fetch_cnt_in,     // Fetch cycles
  input  wire logic [XST_CNT_W-1:0] branch_cnt_in,    // Branch address reads
  input  wire logic [XST_CNT_W-1:0] stack_cnt_in,     // Stack cycles
  input  wire logic [XST_CNT_W-1:0] byte_cnt_in,      // Byte data accesses
  input  wire logic [XST_CNT_W-1:0] word_cnt_in,      // Word data accesses
  input  wire logic [XST_CNT_W-1:0] internal_cnt_in,  // Internal cycles
  input  wire logic                 data_periph_in,   // Data goes to a peripheral
  input  wire logic                 periph_slow_in,   // Peripheral needs three states
  output logic                      is_bitop_out,     // Opcode is a 4-byte bit op
  output logic                      inverted_out,     // Inverted variant chosen
  output logic                      reg_form_out,     // Register-indirect form
  output logic [3:0]                reg_sel_out,      // Register designator
  output logic [7:0]                abs_addr_out,     // Absolute operand address
  output logic [XST_SUM_W-1:0]      states_out,       // Execution states
  output logic                      states_valid_out  // One-cycle result strobe
);
  // ==========================================================
  // Decode
  // Only first bytes 7C to 7F count as four-byte bit operations; every other
  // opcode clears the flags but leaves the captured register and address fields,
  // so a consumer must qualify the fields with the form flags.
  logic       bitop_r, bitop_nxt, inv_r, inv_nxt, regf_r, regf_nxt;
  logic [3:0] reg_r, reg_nxt;
  logic [7:0] abs_r, abs_nxt;
  logic [3:0] lead;
  logic [3:0] fourth_byte_high_nibble;
  always_comb
  begin
    lead = opcode_in[31:28];
    fourth_byte_high_nibble = opcode_in[7:4];
    regf_nxt = (lead == XST_OP_REG_IND0) &&
               ((opcode_in[27:24] == XST_OP_IND_LO) || (opcode_in[27:24] == XST_OP_IND_HI));
    bitop_nxt = regf_nxt || ((lead == XST_OP_REG_IND0) &&
               ((opcode_in[27:24] == XST_OP_ABS_LO) || (opcode_in[27:24] == XST_OP_ABS_HI)));
    inv_nxt = bitop_nxt && fourth_byte_high_nibble[XST_INV_BIT-4];
    reg_nxt = regf_nxt ? opcode_in[23:20] : reg_r;
    abs_nxt = (bitop_nxt && !regf_nxt) ? opcode_in[23:16] : abs_r;
  end
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      bitop_r <= 1'b0;
      inv_r   <= 1'b0;
      regf_r  <= 1'b0;
      reg_r   <= 4'h0;
      abs_r   <= 8'h00;
    end
    else
    begin
      bitop_r <= bitop_nxt;
      inv_r   <= inv_nxt;
      regf_r  <= regf_nxt;
      reg_r   <= reg_nxt;
      abs_r   <= abs_nxt;
    end
  end
  assign is_bitop_out = bitop_r;
  assign inverted_out = inv_r;
  assign reg_form_out = regf_r;
  assign reg_sel_out  = reg_r;
  assign abs_addr_out = abs_r;

  // ==========================================================
  // State count
  // Data cost follows the location; instruction-side cycles always hit memory.
  // Every count is widened before it is multiplied, so a count of fifteen at
  // three states cannot wrap inside a four-bit product.
  logic [XST_SUM_W-1:0] sum_r, sum_nxt;
  logic                 vld_r, vld_nxt;
  logic [3:0]           s_data;
  logic [XST_CNT_W-1:0] cnt_of [6];
  logic [3:0]           cost_of [6];
  logic [XST_SUM_W-1:0] term [6];
  always_comb
  begin
    s_data = data_periph_in ? (periph_slow_in ? XST_S_PERIPH_3 : XST_S_PERIPH_2)
                            : XST_S_MEM;
    cnt_of[0]  = fetch_cnt_in;
    cost_of[0] = XST_S_MEM;
    cnt_of[1]  = branch_cnt_in;
    cost_of[1] = XST_S_MEM;
    cnt_of[2]  = stack_cnt_in;
    cost_of[2] = XST_S_MEM;
    cnt_of[3]  = byte_cnt_in;
    cost_of[3] = s_data;
    cnt_of[4]  = word_cnt_in;
    cost_of[4] = s_data;
    cnt_of[5]  = internal_cnt_in;
    cost_of[5] = XST_S_INTERNAL;
  end
  for (genvar g = 0; g < 6; g++)
  begin : g_term
    assign term[g] = XST_SUM_W'(cnt_of[g]) * XST_SUM_W'(cost_of[g]);
  end
  always_comb
  begin
    vld_nxt = calc_start_in;
    sum_nxt = sum_r;
    if (calc_start_in)
      sum_nxt = term[0] + term[1] + term[2] + term[3] + term[4] + term[5];
  end
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      sum_r <= '0;
      vld_r <= 1'b0;
    end
    else
    begin
      sum_r <= sum_nxt;
      vld_r <= vld_nxt;
    end
  end
  assign states_out       = sum_r;
  assign states_valid_out = vld_r;

  // ==========================================================
  // Checks
  // Every check but chk_form_implies looks one edge after a start or an opcode, where the registered
  // answer first stands; the cost checks but chk_bitset_eight and chk_jump_eight use single-type counts so that
  // each per-cycle cost is seen on its own.
  sequence s_start;
    calc_start_in && !data_periph_in;
  endsequence
  sequence s_periph_start;
    calc_start_in && data_periph_in;
  endsequence
  sequence s_idle;
    !calc_start_in;
  endsequence
  sequence s_only_byte;
    byte_cnt_in == 4'h1 && fetch_cnt_in == 4'h0 && branch_cnt_in == 4'h0
    && stack_cnt_in == 4'h0 && word_cnt_in == 4'h0 && internal_cnt_in == 4'h0;
  endsequence
  sequence s_only_word;
    word_cnt_in == 4'h1 && fetch_cnt_in == 4'h0 && branch_cnt_in == 4'h0
    && stack_cnt_in == 4'h0 && byte_cnt_in == 4'h0 && internal_cnt_in == 4'h0;
  endsequence
  sequence s_only_internal;
    internal_cnt_in == 4'h1 && fetch_cnt_in == 4'h0 && branch_cnt_in == 4'h0
    && stack_cnt_in == 4'h0 && byte_cnt_in == 4'h0 && word_cnt_in == 4'h0;
  endsequence
  chk_mem_sum: assert property (@(posedge mclk_in) disable iff (reset_in)
    s_start |=> states_out == XST_SUM_W'(2*($past(fetch_cnt_in) + $past(branch_cnt_in)
      + $past(stack_cnt_in) + $past(byte_cnt_in) + $past(word_cnt_in)) + $past(internal_cnt_in)))
    else $error("state sum wrong");
  chk_fetch_cost: assert property (@(posedge mclk_in) disable iff (reset_in)
    (calc_start_in && fetch_cnt_in == 4'h1 && branch_cnt_in == 4'h0 && stack_cnt_in == 4'h0
     && byte_cnt_in == 4'h0 && word_cnt_in == 4'h0 && internal_cnt_in == 4'h0)
    |=> states_out == 12'h002) else $error("fetch cost not two");
  chk_bitset_eight: assert property (@(posedge mclk_in) disable iff (reset_in)
    (s_start and (fetch_cnt_in == 4'h2 && byte_cnt_in == 4'h2 && branch_cnt_in == 4'h0
     && stack_cnt_in == 4'h0 && word_cnt_in == 4'h0 && internal_cnt_in == 4'h0))
    |=> states_out == 12'h008) else $error("bit set not eight states");
  chk_inv_select: assert property (@(posedge mclk_in) disable iff (reset_in)
    bitop_nxt |=> inverted_out == $past(opcode_in[7])) else $error("variant select wrong");
  chk_reg_field: assert property (@(posedge mclk_in) disable iff (reset_in)
    regf_nxt |=> reg_sel_out == $past(opcode_in[23:20])) else $error("register field wrong");
  chk_abs_field: assert property (@(posedge mclk_in) disable iff (reset_in)
    (bitop_nxt && !regf_nxt) |=> abs_addr_out == $past(opcode_in[23:16]))
    else $error("absolute field wrong");
  chk_periph_cost: assert property (@(posedge mclk_in) disable iff (reset_in)
    (calc_start_in && data_periph_in && periph_slow_in && byte_cnt_in == 4'h1
     && fetch_cnt_in == 4'h0 && branch_cnt_in == 4'h0 && stack_cnt_in == 4'h0
     && word_cnt_in == 4'h0 && internal_cnt_in == 4'h0)
    |=> states_out == 12'h003) else $error("peripheral cost wrong");
  chk_valid_pulse: assert property (@(posedge mclk_in) disable iff (reset_in)
    calc_start_in |=> states_valid_out) else $error("result strobe missing");

  // Costs and the full sum when the data cycles leave on-chip memory, then memory word, internal and branch-plus-stack costs.
  chk_fast_cost: assert property (@(posedge mclk_in) disable iff (reset_in)
    (s_periph_start and s_only_byte and (!periph_slow_in)) |=> states_out == 12'h002)
    else $error("fast peripheral cost wrong");
  chk_word_slow: assert property (@(posedge mclk_in) disable iff (reset_in)
    (s_periph_start and s_only_word and periph_slow_in) |=> states_out == 12'h003)
    else $error("slow peripheral word cost wrong");
  chk_periph_sum: assert property (@(posedge mclk_in) disable iff (reset_in)
    s_periph_start |=> states_out == XST_SUM_W'(2*($past(fetch_cnt_in) + $past(branch_cnt_in)
      + $past(stack_cnt_in)) + ($past(periph_slow_in) ? 3 : 2)*($past(byte_cnt_in)
      + $past(word_cnt_in)) + $past(internal_cnt_in)))
    else $error("peripheral state sum wrong");
  chk_word_mem: assert property (@(posedge mclk_in) disable iff (reset_in)
    (s_start and s_only_word) |=> states_out == 12'h002) else $error("memory word cost wrong");
  chk_internal_one: assert property (@(posedge mclk_in) disable iff (reset_in)
    (calc_start_in and s_only_internal) |=> states_out == 12'h001)
    else $error("internal cost not one");
  chk_jump_eight: assert property (@(posedge mclk_in) disable iff (reset_in)
    (s_start and (fetch_cnt_in == 4'h2 && branch_cnt_in == 4'h1 && stack_cnt_in == 4'h1
     && byte_cnt_in == 4'h0 && word_cnt_in == 4'h0 && internal_cnt_in == 4'h0))
    |=> states_out == 12'h008) else $error("branch and stack cost wrong");

  // The result strobe lasts one cycle and the count holds between starts.
  chk_valid_drop: assert property (@(posedge mclk_in) disable iff (reset_in)
    s_idle |=> !states_valid_out) else $error("result strobe too long");
  chk_sum_hold: assert property (@(posedge mclk_in) disable iff (reset_in)
    s_idle |=> $stable(states_out)) else $error("state count moved without start");

  // Decode flags and captured fields.
  chk_plain_select: assert property (@(posedge mclk_in) disable iff (reset_in)
    (bitop_nxt && !opcode_in[7]) |=> !inverted_out) else $error("plain variant wrong");
  chk_non_bitop: assert property (@(posedge mclk_in) disable iff (reset_in)
    !bitop_nxt |=> !is_bitop_out && !inverted_out && !reg_form_out)
    else $error("flags set for other opcode");
  chk_reg_form: assert property (@(posedge mclk_in) disable iff (reset_in)
    regf_nxt |=> reg_form_out && is_bitop_out) else $error("register form flag wrong");
  chk_abs_form: assert property (@(posedge mclk_in) disable iff (reset_in)
    (bitop_nxt && !regf_nxt) |=> is_bitop_out && !reg_form_out) else $error("absolute form flag wrong");
  chk_reg_hold: assert property (@(posedge mclk_in) disable iff (reset_in)
    !regf_nxt |=> $stable(reg_sel_out)) else $error("register field not held");
  chk_abs_hold: assert property (@(posedge mclk_in) disable iff (reset_in)
    !(bitop_nxt && !regf_nxt) |=> $stable(abs_addr_out)) else $error("address field not held");
  chk_form_implies: assert property (@(posedge mclk_in) disable iff (reset_in)
    reg_form_out |-> is_bitop_out) else $error("register form without bit op");
endmodule
`default_nettype wire

//--- sim/xst_bus_model.sv
// Data-side access location model for the state calculator.
// Assumes the bench chooses a location code for each instruction.
`timescale 1ns/1ps
`default_nettype none
module xst_bus_model
(
  input  wire logic [1:0] loc_in,     // 0 memory, 2 fast, 3 slow peripheral
  output logic            periph_out, // Data goes to a peripheral
  output logic            slow_out    // Peripheral takes three states
);
  // Fetch, branch and stack cycles always hit on-chip memory here.
  assign periph_out = loc_in[1];
  assign slow_out   = loc_in[1] & loc_in[0];
endmodule
`default_nettype wire

//--- sim/cpu_exec_state_timing_decode_bench.sv
// Table-driven bench for bit-operation decode fields and state counts.
// Assumes the bus model sets the access location of the data cycles.
`timescale 1ns/1ps
`default_nettype none
module cpu_exec_state_timing_decode_bench;
  import xst_pkg::*;
  typedef struct packed {logic [31:0] op; logic [23:0] cnt; logic [1:0] loc;} xst_row_t;
  localparam xst_row_t ROWS [11] = '{'{32'h7c500080, 24'h200200, 2'h0},
    '{32'h7d300070, 24'h211000, 2'h0}, '{32'h7eff0060, 24'h100110, 2'h3},
    '{32'h7f0000f0, 24'h000013, 2'h2}, '{32'h6a123480, 24'hfff0ff, 2'h3},
    '{32'h00000000, 24'h100000, 2'h0}, '{32'h7ca10000, 24'h000100, 2'h3},
    '{32'h7e5a0000, 24'h000100, 2'h2}, '{32'h12345678, 24'h000010, 2'h0},
    '{32'h7d900080, 24'h000010, 2'h3}, '{32'h7f7e0000, 24'h000001, 2'h1}};
  logic mclk_in = 1'b0, reset_in = 1'b1, calc_start_in = 1'b0, data_periph_in, periph_slow_in;
  logic [31:0] opcode_in = 32'h0;
  logic [23:0] cnt = 24'h0;
  logic [1:0] loc = 2'h0;
  logic is_bitop_out, inverted_out, reg_form_out, states_valid_out;
  logic [3:0] reg_sel_out, ers = 4'h0;
  logic [7:0] abs_addr_out, eaa = 8'h0;
  logic [XST_SUM_W-1:0] states_out;
  int n_fail = 0, comparisons = 0;
  xst_bus_model xst_bus_model_i (.loc_in(loc), .periph_out(data_periph_in),
    .slow_out(periph_slow_in));
  xst_exec_timing xst_exec_timing_i (.mclk_in, .reset_in, .opcode_in, .calc_start_in,
    .fetch_cnt_in(cnt[23:20]), .branch_cnt_in(cnt[19:16]), .stack_cnt_in(cnt[15:12]),
    .byte_cnt_in(cnt[11:8]), .word_cnt_in(cnt[7:4]), .internal_cnt_in(cnt[3:0]),
    .data_periph_in, .periph_slow_in, .is_bitop_out, .inverted_out, .reg_form_out,
    .reg_sel_out, .abs_addr_out, .states_out, .states_valid_out);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic drive(input xst_row_t r, input logic go);
    opcode_in = r.op;
    cnt = r.cnt;
    loc = r.loc;
    calc_start_in = go;
    @(negedge mclk_in);
  endtask
  // Checks outputs one cycle after the row was applied, or two cycles after with v low.
  task automatic chk_row(input xst_row_t r, input logic v);
    logic [11:0] sd;
    sd = (r.loc == 2'h3) ? 12'h3 : 12'h2;
    if (r.op[31:25] == 7'h3e)
      ers = r.op[23:20];
    if (r.op[31:25] == 7'h3f)
      eaa = r.op[23:16];
    chk(is_bitop_out, r.op[31:26] == 6'h1f);
    chk({inverted_out, reg_form_out}, {r.op[31:26] == 6'h1f && r.op[7], r.op[31:25] == 7'h3e});
    chk({reg_sel_out, abs_addr_out}, {ers, eaa});
    chk(states_out, 12'h2 * (r.cnt[23:20] + r.cnt[19:16] + r.cnt[15:12])
      + sd * (r.cnt[11:8] + r.cnt[7:4]) + r.cnt[3:0]);
    chk(states_valid_out, v);
  endtask
  initial
  begin
    forever #2 mclk_in = ~mclk_in;
  end
  initial
  begin
    #20000;
    n_fail++;
    close_out();
  end
  // ==========================================================
  // Reset, table rows, then back-to-back starts.
  initial
  begin
    repeat (6) @(negedge mclk_in);
    chk({is_bitop_out, inverted_out, reg_form_out, reg_sel_out, abs_addr_out,
      states_out, states_valid_out}, 32'h0);
    reset_in = 1'b0;
    for (int i = 0; i < 11; i++)
    begin
      drive(ROWS[i], 1'b1);
      calc_start_in = 1'b0;
      chk_row(ROWS[i], 1'b1);
      @(negedge mclk_in);
      chk_row(ROWS[i], 1'b0);
    end
    drive(ROWS[0], 1'b1);
    chk_row(ROWS[0], 1'b1);
    drive(ROWS[2], 1'b1);
    calc_start_in = 1'b0;
    chk_row(ROWS[2], 1'b1);
    // A reset in mid-run clears every output, captured fields included.
    reset_in = 1'b1;
    @(negedge mclk_in);
    chk({is_bitop_out, inverted_out, reg_form_out, reg_sel_out, abs_addr_out,
      states_out, states_valid_out}, 32'h0);
    {ers, eaa} = 12'h0;
    reset_in = 1'b0;
    drive(ROWS[3], 1'b1);
    calc_start_in = 1'b0;
    chk_row(ROWS[3], 1'b1);
    close_out();
  end
endmodule
`default_nettype wire
